/* bench/gds_out_reader.sv */
// monitoring reader on the proportional output wire
`timescale 1ns/1ps
`default_nettype none
module gds_out_reader
  import gds_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // wire code and reader alarm point in steps
  input  wire logic [5:0] dacCode,
  input  wire logic [5:0] alarmRu,
  // derived view
  output var  logic       wireOk,
  output var  logic       alarmSeen
);
  logic [5:0] netRu;
  assign netRu = dacCode - DAC_OFFSET;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wireOk    <= 1'b0;
      alarmSeen <= 1'b0;
    end else begin
      wireOk    <= dacCode >= DAC_OFFSET;
      alarmSeen <= dacCode >= DAC_OFFSET && netRu >= alarmRu;
    end
  end
endmodule
`default_nettype wire

/* bench/gds_state_ctrl_sva.sv */
// assertion checker for the gas detector state controller
`timescale 1ns/1ps
`default_nettype none
module gds_state_ctrl_sva
  import gds_pkg::*;
#(
  parameter logic [31:0] WarmupCycles = 32'd200
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  input  wire logic [7:0] regRdData,
  // sensor side
  input  wire logic [7:0] adcSample,
  input  wire logic [7:0] tempCode,
  input  wire logic       sensorFault,
  input  wire logic       tempFault,
  input  wire logic       powerGood,
  input  wire logic       checksumBad,
  // outputs
  input  wire logic [5:0] dacCode,
  input  wire logic       binOut,
  input  wire logic       ledRed,
  input  wire logic       ledGreen
);
  logic [7:0]  ctrlQ;
  logic [31:0] pgCnt;
  logic        warmDone;
  logic        stepM;
  logic        propM;
  // slack of 8 covers input sync and output register
  assign warmDone = pgCnt > WarmupCycles + 32'd8;
  assign stepM    = ctrlQ[1:0] == 2'd1;
  assign propM    = ctrlQ[1:0] == 2'd2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlQ <= CTRL_RST;
      pgCnt <= '0;
    end else begin
      if (regWr && regAddr == REG_CTRL) ctrlQ <= regWrData;
      pgCnt <= powerGood ? pgCnt + {31'd0, !warmDone} : '0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_held(logic [5:0] v);
    (stepM && dacCode == v) [*2];
  endsequence
  dac_idle_a: assert property ((!stepM && !propM) [*3] |-> dacCode == 6'h00)
    else $error("converter not idle");
  // binary pin quiet in other modes
  bin_quiet_a: assert property ((ctrlQ[1:0] != 2'd0) [*3] |-> !binOut)
    else $error("binary pin active outside binary mode");
  step_lvl_a: assert property (stepM [*3] |-> dacCode inside {STEP_ERROR,
    STEP_NORMAL, STEP_WARN, STEP_ALARM}) else $error("bad step level");
  prop_ofs_a: assert property (propM [*3] |-> dacCode == 6'h00 ||
    dacCode >= DAC_OFFSET) else $error("offset missing");
  err_dark_a: assert property (s_held(STEP_ERROR) |-> !ledGreen)
    else $error("green lit in error");
  alarm_led_a: assert property (s_held(STEP_ALARM) |-> !ledGreen)
    else $error("green lit in alarm");
  warn_led_a: assert property (s_held(STEP_WARN) |-> ledRed != ledGreen)
    else $error("warning colours wrong");
  norm_led_a: assert property (s_held(STEP_NORMAL) |-> !ledRed)
    else $error("red lit in normal");
  chk_err_a: assert property ((stepM && warmDone && checksumBad) [*3]
    |-> dacCode == STEP_ERROR) else $error("checksum fault ignored");
  warm_dac_a: assert property (stepM [*3] ##0 (pgCnt > 32'd3 &&
    pgCnt < WarmupCycles) |-> dacCode == STEP_NORMAL) else $error("warm-up level");
  rd_idle_a: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data not idle");
  ctrl_rb_a: assert property (regRd && regAddr == REG_CTRL |=>
    regRdData == {1'b0, ctrlQ[6:0]}) else $error("control readback");
endmodule
bind gds_state_ctrl gds_state_ctrl_sva #(.WarmupCycles(WarmupCycles)) u_sva (
  .clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .adcSample,
  .tempCode, .sensorFault, .tempFault, .powerGood, .checksumBad, .dacCode,
  .binOut, .ledRed, .ledGreen);
`default_nettype wire

/* bench/gds_state_ctrl_tb.sv */
// self-checking bench for the gas detector state controller
`timescale 1ns/1ps
`default_nettype none
module gds_state_ctrl_tb
  import gds_pkg::*;
;
  typedef struct packed { logic [3:0] kind; logic [7:0] exp; } gds_note_t;
  logic        clk, rst_n, regWr, regRd, sensorFault, tempFault, powerGood;
  logic        checksumBad, binOut, ledRed, ledGreen, want, wantD, clr;
  logic        rP, gP, wireOk, alarmSeen;
  logic [2:0]  regAddr;
  logic [7:0]  regWrData, regRdData, adcSample, tempCode, got, rC, gC;
  logic [5:0]  dacCode;
  logic [31:0] rng;
  int          num_errors, checks;
  gds_note_t   notes[$];
  gds_note_t   nt;
  logic [7:0]  rv[6] = '{CTRL_RST, ALARM_RST, WARNPCT_RST, BASE_RST, SPAN_RST,
                         TCOEF_RST};
  // ctrl, threshold, percent, expected pin
  logic [31:0] tbl[11] = '{32'h00ff0001, 32'h00000000, 32'h10ff0000,
    32'h10000001, 32'h20ff0001, 32'h20000001, 32'h14000000, 32'h14ff6401,
    32'h18000001, 32'h18ff6401, 32'h98ff6400};
  string       nm[8] = '{"rdata", "state", "dac", "bin", "green", "mixed",
                         "blinks", "reader"};

  gds_state_ctrl #(.WarmupCycles(32'd200), .BlinkCycles(32'd8),
    .ErrPeriodCycles(32'd100), .ErrPulseCycles(32'd10)) dut (
    .clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .adcSample, .tempCode, .sensorFault, .tempFault, .powerGood,
    .checksumBad, .dacCode, .binOut, .ledRed, .ledGreen);
  gds_out_reader rdr (.clk, .rst_n, .dacCode, .alarmRu(6'h01), .wireOk,
    .alarmSeen);

  always #5 clk = ~clk;

  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    {regWr, regAddr, regWrData} <= {1'b1, a, d};
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  // note an expectation; the watcher compares two edges on
  task automatic look(input logic r, input logic [2:0] a, input logic [3:0] k,
                      input logic [7:0] e);
    notes.push_back('{k, e});
    {want, regRd, regAddr} <= {1'b1, r, a};
    @(posedge clk);
    {want, regRd} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic blinks(input int n, input logic [7:0] e);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(n);
    look(0, 3'h0, 4'd6, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    wantD <= want;
    {rP, gP} <= {ledRed, ledGreen};
    if (clr) {rC, gC} <= '0;
    else {rC, gC} <= {rC + 8'(ledRed && !rP), gC + 8'(ledGreen && !gP)};
    if (wantD) begin
      nt = notes.pop_front();
      case (nt.kind)
        4'd1: got = {5'd0, regRdData[2:0]};
        4'd2: got = {2'd0, dacCode};
        4'd3: got = {7'd0, binOut};
        4'd4: got = {7'd0, ledGreen};
        4'd5: got = {7'd0, ledRed ^ ledGreen};
        4'd6: got = {6'd0, rC != 8'd0, gC != 8'd0};
        4'd7: got = {6'd0, wireOk, alarmSeen};
        default: got = regRdData;
      endcase
      checks++;
      if (got !== nt.exp) begin
        num_errors++;
        $display("Error %s expected %h seen %h", nm[nt.kind], nt.exp, got);
      end
    end
  end

  initial begin
    #1_000_000;
    num_errors++;
    wrap_up();
  end

  initial begin
    {clk, rst_n, regWr, regRd, want, clr, regAddr, regWrData} = '0;
    {sensorFault, tempFault, checksumBad, adcSample} = '0;
    {powerGood, tempCode, rng} = {1'b1, TEMP_REF, 32'd69339};
    tick(12);
    rst_n <= 1'b1;
    @(posedge clk);
    look(1, REG_STATUS, 4'd1, 8'h00);
    foreach (rv[i]) look(1, 3'(i), 4'd0, rv[i]);
    for (int i = 1; i < 6; i++) begin
      wr(3'(i), rnd());
      look(1, 3'(i), 4'd0, rng[7:0]);
      wr(3'(i), rv[i]);
    end
    wr(REG_READING, 8'hff);
    look(1, REG_READING, 4'd0, 8'h00);
    wr(REG_CTRL, 8'h01);
    look(0, 3'h0, 4'd2, {2'd0, STEP_NORMAL});
    blinks(60, 8'h01);
    $display("warm-up done");
    tick(200);
    look(1, REG_STATUS, 4'd1, 8'h01);
    look(0, 3'h0, 4'd4, 8'h01);
    blinks(60, 8'h00);
    wr(REG_ALARM, 8'hff);
    wr(REG_WARNPCT, 8'h00);
    adcSample <= rnd();
    tick(8);
    look(1, REG_STATUS, 4'd1, 8'h02);
    look(0, 3'h0, 4'd2, {2'd0, STEP_WARN});
    look(0, 3'h0, 4'd5, 8'h01);
    blinks(60, 8'h03);
    wr(REG_ALARM, 8'h00);
    tick(8);
    look(1, REG_STATUS, 4'd1, 8'h03);
    look(0, 3'h0, 4'd2, {2'd0, STEP_ALARM});
    blinks(60, 8'h02);
    for (int c = 0; c < 3; c++) begin
      if (c == 2) wr(REG_CTRL, 8'h41);
      {sensorFault, tempFault, checksumBad, adcSample} <= {3'b100 >> c, rnd()};
      tick(8);
      look(1, REG_STATUS, 4'd1, 8'h04);
      look(0, 3'h0, 4'd2, {2'd0, STEP_ERROR});
      look(1, REG_READING, 4'd0, c == 2 ? READ_FULL : READ_ERRIND);
      if (c == 0) blinks(130, 8'h02);
      {sensorFault, tempFault, checksumBad} <= 3'b000;
      tick(8);
      look(1, REG_STATUS, 4'd1, 8'h03);
    end
    $display("states done");
    wr(REG_ALARM, 8'hff);
    wr(REG_WARNPCT, 8'h64);
    wr(REG_CTRL, 8'h02);
    adcSample <= 8'h00;
    tick(4000);
    look(1, REG_STATUS, 4'd1, 8'h01);
    look(0, 3'h0, 4'd2, {2'd0, DAC_OFFSET});
    look(0, 3'h0, 4'd7, 8'h02);
    checksumBad <= 1'b1;
    tick(8);
    look(0, 3'h0, 4'd7, 8'h00);
    checksumBad <= 1'b0;
    foreach (tbl[i]) begin
      wr(REG_CTRL, tbl[i][31:24]);
      wr(REG_ALARM, tbl[i][23:16]);
      wr(REG_WARNPCT, tbl[i][15:8]);
      adcSample <= rnd();
      tick(8);
      look(0, 3'h0, 4'd3, {7'd0, tbl[i][0]});
    end
    $display("binary done");
    powerGood <= 1'b0;
    tick(4);
    powerGood <= 1'b1;
    tick(6);
    look(1, REG_STATUS, 4'd1, 8'h00);
    look(1, REG_READING, 4'd0, 8'h00);
    tick(4);
    wrap_up();
  end
endmodule
`default_nettype wire

/* hw/gds_led_drive.sv */
// bi-color status indicator pattern generator
`timescale 1ns/1ps
`default_nettype none
module gds_led_drive
  import gds_pkg::*;
#(
  parameter logic [31:0] BlinkCycles    = 32'(BLINK_CYC),
  parameter logic [31:0] ErrPeriodCycles = 32'(ERRPER_CYC),
  parameter logic [31:0] ErrPulseCycles = 32'(ERRPULSE_CYC)
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // detector state
  input  wire gds_state_t state,
  // indicator drive
  output var  logic       ledRed,
  output var  logic       ledGreen
);
  logic [31:0] blinkCnt_q;
  logic        phase_q;
  logic [31:0] errCnt_q;
  wire         blinkWrap = (blinkCnt_q == BlinkCycles - 32'd1);
  wire         errWrap   = (errCnt_q == ErrPeriodCycles - 32'd1);
  // pulse sits at the end of each period, so a new error waits a while
  wire         errPulse  = (errCnt_q >= ErrPeriodCycles - ErrPulseCycles);
  logic        red_d;
  logic        green_d;

  always_comb begin
    red_d   = 1'b0;
    green_d = 1'b0;
    unique case (state)
      ST_WARMUP:  green_d = phase_q;
      ST_NORMAL:  green_d = 1'b1;
      ST_WARNING: begin
        red_d   = phase_q;
        green_d = ~phase_q;
      end
      ST_ALARM:   red_d = phase_q;
      ST_ERROR:   red_d = errPulse;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blinkCnt_q <= 32'd0;
      phase_q    <= 1'b0;
      errCnt_q   <= 32'd0;
      ledRed     <= 1'b0;
      ledGreen   <= 1'b0;
    end else begin
      blinkCnt_q <= blinkWrap ? 32'd0 : blinkCnt_q + 32'd1;
      phase_q    <= blinkWrap ? ~phase_q : phase_q;
      errCnt_q   <= (state != ST_ERROR || errWrap) ? 32'd0
                                                   : errCnt_q + 32'd1;
      ledRed     <= red_d;
      ledGreen   <= green_d;
    end
  end
endmodule
`default_nettype wire

/* hw/gds_pkg.sv */
// shared constants and types for the gas detector state controller
`default_nettype none
package gds_pkg;
  localparam longint unsigned CLK_HZ        = 100_000_000;
  localparam longint unsigned CLK_NS        = 10;
  localparam longint unsigned WARMUP_S      = 30;
  localparam longint unsigned WARMUP_CYC    = WARMUP_S * CLK_HZ;
  localparam longint unsigned BLINK_MS      = 250;
  localparam longint unsigned BLINK_CYC     = BLINK_MS * CLK_HZ / 1000;
  localparam longint unsigned ERRPER_S      = 10;
  localparam longint unsigned ERRPER_CYC    = ERRPER_S * CLK_HZ;
  localparam longint unsigned ERRPULSE_MS   = 100;
  localparam longint unsigned ERRPULSE_CYC  = ERRPULSE_MS * CLK_HZ / 1000;
  localparam longint unsigned SAMPLE_NS     = 2560;
  localparam logic [8:0]      SAMPLE_CYC    = 9'(SAMPLE_NS / CLK_NS);
  // register indices on the plain register port
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_ALARM   = 3'h1;
  localparam logic [2:0] REG_WARNPCT = 3'h2;
  localparam logic [2:0] REG_BASE    = 3'h3;
  localparam logic [2:0] REG_SPAN    = 3'h4;
  localparam logic [2:0] REG_TCOEF   = 3'h5;
  localparam logic [2:0] REG_STATUS  = 3'h6;
  localparam logic [2:0] REG_READING = 3'h7;
  localparam logic [7:0] CTRL_RST    = 8'h02;
  localparam logic [7:0] ALARM_RST   = 8'h28;
  localparam logic [7:0] WARNPCT_RST = 8'h32;
  localparam logic [7:0] BASE_RST    = 8'h20;
  localparam logic [7:0] SPAN_RST    = 8'h40;
  localparam logic [7:0] TCOEF_RST   = 8'h00;
  localparam logic [7:0] TEMP_REF    = 8'h80;
  localparam logic [7:0] READ_FULL   = 8'hff;
  localparam logic [7:0] READ_ERRIND = 8'hfe;
  localparam logic [5:0] DAC_OFFSET  = 6'h07;
  localparam logic [5:0] DAC_MAX     = 6'h3f;
  localparam logic [5:0] STEP_ERROR  = 6'h00;
  localparam logic [5:0] STEP_NORMAL = 6'h10;
  localparam logic [5:0] STEP_WARN   = 6'h20;
  localparam logic [5:0] STEP_ALARM  = 6'h30;
  localparam logic [6:0] PCT_FULL    = 7'h64;
  localparam logic [7:0] LIN_TBL [17] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0c, 8'h10,
    8'h14, 8'h19, 8'h1f, 8'h26, 8'h2e, 8'h38, 8'h44, 8'h52};

  typedef enum logic [2:0] {ST_WARMUP, ST_NORMAL, ST_WARNING, ST_ALARM,
                            ST_ERROR} gds_state_t;
  typedef enum logic [1:0] {MODE_BINARY, MODE_STEP, MODE_PROP} gds_mode_t;
  typedef enum logic [1:0] {SEL_WARN, SEL_ALARM, SEL_EITHER} gds_sel_t;
  typedef struct packed {
    logic      clrLatch;
    logic      errFull;
    logic [1:0] binSel;
    logic      binLatch;
    logic      binIdleHigh;
    logic [1:0] outMode;
  } gds_cfg_t;
  typedef struct packed {
    logic sensor;
    logic temp;
    logic checksum;
  } gds_fault_t;

  function automatic logic [7:0] gds_sat8(input logic signed [17:0] v);
    if (v < 0) return 8'h00;
    if (v > 18'sd255) return 8'hff;
    return v[7:0];
  endfunction
endpackage
`default_nettype wire

/* hw/gds_reading_path.sv */
// sensor sample conditioning: filter, compensation, baseline, span, table
`timescale 1ns/1ps
`default_nettype none
module gds_reading_path
  import gds_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       enable,
  input  wire logic       tick,
  // converter samples
  input  wire logic [7:0] sample,
  input  wire logic [7:0] temp,
  // calibration
  input  wire logic [7:0] baseline,
  input  wire logic [7:0] span,
  input  wire logic [7:0] tcoef,
  // result
  output var  logic [7:0] reading
);
  logic [7:0] filt_q;
  wire signed [8:0]  diff   = $signed({1'b0, sample}) - $signed({1'b0, filt_q});
  wire signed [8:0]  tdiff  = $signed({1'b0, temp}) - $signed({1'b0, TEMP_REF});
  wire signed [17:0] tprod  = 18'(tdiff * $signed(tcoef));
  wire signed [17:0] compS  = $signed({10'd0, filt_q}) - (tprod >>> 4);
  wire [7:0]         comp   = gds_sat8(compS);
  wire [7:0]         base   = gds_sat8($signed({10'd0, comp})
                                     - $signed({10'd0, baseline}));
  wire [15:0]        prod   = 16'(base) * 16'(span);
  wire [7:0]         spanned = gds_sat8($signed({8'd0, prod[15:6]}));
  wire [3:0]         idx    = spanned[7:4];
  wire [7:0]         lo     = LIN_TBL[idx];
  wire [7:0]         hi     = LIN_TBL[5'(idx) + 5'd1];
  wire [11:0]        step   = 12'((hi - lo) * spanned[3:0]);
  wire [7:0]         lin    = lo + step[11:4];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q  <= 8'h00;
      reading <= 8'h00;
    end else if (!enable) begin
      filt_q  <= 8'h00;
      reading <= 8'h00;
    end else if (tick) begin
      filt_q  <= 8'($signed({1'b0, filt_q}) + (diff >>> 2));
      reading <= lin;
    end
  end
endmodule
`default_nettype wire

/* hw/gds_state_ctrl.sv */
// gas detector state controller: states, outputs and register port
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module gds_state_ctrl
  import gds_pkg::*;
#(
  parameter logic [31:0] WarmupCycles    = 32'(WARMUP_CYC),
  parameter logic [31:0] BlinkCycles     = 32'(BLINK_CYC),
  parameter logic [31:0] ErrPeriodCycles = 32'(ERRPER_CYC),
  parameter logic [31:0] ErrPulseCycles  = 32'(ERRPULSE_CYC)
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output var  logic [7:0] regRdData,
  // sensor side pins
  input  wire logic [7:0] adcSample,
  input  wire logic [7:0] tempCode,
  input  wire logic       sensorFault,
  input  wire logic       tempFault,
  input  wire logic       powerGood,
  // firmware integrity, same clock
  input  wire logic       checksumBad,
  // output converter and binary pin
  output var  logic [5:0] dacCode,
  output var  logic       binOut,
  // status indicator
  output var  logic       ledRed,
  output var  logic       ledGreen
);
  localparam int PW = 19;

  // pin synchronisers
  logic [PW-1:0] pinS1_q;
  logic [PW-1:0] pinS2_q;
  wire  [PW-1:0] pinRaw = {adcSample, tempCode, sensorFault,
                           tempFault, powerGood};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_q <= '0;
      pinS2_q <= '0;
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
    end
  end

  // multi-bit pin words can tear while they change, so a word is
  // taken only once it reads the same on two edges in a row
  logic [15:0] wordS3_q;
  logic [15:0] word_q;
  wire         wordSteady = (pinS2_q[18:3] == wordS3_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wordS3_q <= {8'h00, TEMP_REF};
      word_q   <= {8'h00, TEMP_REF};
    end else begin
      wordS3_q <= pinS2_q[18:3];
      if (wordSteady) word_q <= wordS3_q;
    end
  end

  wire [7:0]  adcS   = word_q[15:8];
  wire [7:0]  tempS  = word_q[7:0];
  wire        pwrOk  = pinS2_q[0];
  gds_fault_t faults;
  assign faults.sensor   = pinS2_q[2];
  assign faults.temp     = pinS2_q[1];
  assign faults.checksum = checksumBad;
  wire        faultAny = |faults;

  // configuration registers
  gds_cfg_t   cfg_q;
  logic [7:0] alarmThr_q;
  logic [7:0] warnPct_q;
  logic [7:0] baseline_q;
  logic [7:0] span_q;
  logic [7:0] tcoef_q;

  wire wrCtrl  = regWr && (regAddr == REG_CTRL);
  wire wrAlarm = regWr && (regAddr == REG_ALARM);
  wire wrPct   = regWr && (regAddr == REG_WARNPCT);
  wire wrBase  = regWr && (regAddr == REG_BASE);
  wire wrSpan  = regWr && (regAddr == REG_SPAN);
  wire wrTcoef = regWr && (regAddr == REG_TCOEF);
  gds_cfg_t wrCfg;
  assign wrCfg = gds_cfg_t'(regWrData);
  // clear bit acts on the write only, never stored
  wire clrLatchReq = wrCtrl && wrCfg.clrLatch;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q      <= gds_cfg_t'(CTRL_RST);
      alarmThr_q <= ALARM_RST;
      warnPct_q  <= WARNPCT_RST;
      baseline_q <= BASE_RST;
      span_q     <= SPAN_RST;
      tcoef_q    <= TCOEF_RST;
    end else begin
      if (wrCtrl) begin
        cfg_q          <= wrCfg;
        cfg_q.clrLatch <= 1'b0;
      end
      if (wrAlarm) alarmThr_q <= regWrData;
      if (wrPct)   warnPct_q  <= regWrData;
      if (wrBase)  baseline_q <= regWrData;
      if (wrSpan)  span_q     <= regWrData;
      if (wrTcoef) tcoef_q    <= regWrData;
    end
  end

  // warm-up timer, restarted whenever supply drops out
  logic [31:0] warmCnt_q;
  logic        warmDone_q;
  wire         warmEnd = (warmCnt_q == WarmupCycles - 32'd1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warmCnt_q  <= 32'd0;
      warmDone_q <= 1'b0;
    end else if (!pwrOk) begin
      warmCnt_q  <= 32'd0;
      warmDone_q <= 1'b0;
    end else if (!warmDone_q) begin
      warmCnt_q  <= warmEnd ? 32'd0 : warmCnt_q + 32'd1;
      warmDone_q <= warmEnd;
    end
  end

  // sample pacing for the conditioning chain
  logic [8:0] tickCnt_q;
  wire        tickEnd = (tickCnt_q == SAMPLE_CYC - 9'd1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tickCnt_q <= 9'd0;
    else        tickCnt_q <= tickEnd ? 9'd0 : tickCnt_q + 9'd1;
  end

  logic [7:0] rdg;

  // sensing held off until warm-up ends
  gds_reading_path u_path (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (warmDone_q),
    .tick     (tickEnd),
    .sample   (adcS),
    .temp     (tempS),
    .baseline (baseline_q),
    .span     (span_q),
    .tcoef    (tcoef_q),
    .reading  (rdg)
  );

  // threshold compares; percent applied by cross-multiplying
  wire [15:0] rdgScaled  = 16'(rdg) * 16'(PCT_FULL);
  wire [15:0] warnScaled = 16'(alarmThr_q) * 16'(warnPct_q);
  wire        alarmHit   = (rdg >= alarmThr_q);
  wire        warnHit    = (rdgScaled >= warnScaled);

  // state machine
  gds_state_t state_q;
  gds_state_t state_d;

  always_comb begin
    state_d = ST_NORMAL;
    if (!warmDone_q)   state_d = ST_WARMUP;
    else if (faultAny) state_d = ST_ERROR;
    else if (alarmHit) state_d = ST_ALARM;
    else if (warnHit)  state_d = ST_WARNING;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_q <= ST_WARMUP;
    else        state_q <= state_d;
  end

  wire inWarm  = (state_q == ST_WARMUP);
  wire inWarn  = (state_q == ST_WARNING);
  wire inAlarm = (state_q == ST_ALARM);
  wire inError = (state_q == ST_ERROR);

  // reported reading
  logic [7:0] reading_q;
  logic [7:0] reading_d;

  always_comb begin
    reading_d = rdg;
    if (inWarm) reading_d = 8'h00;
    else if (inError) reading_d = cfg_q.errFull ? READ_FULL : READ_ERRIND;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reading_q <= 8'h00;
    else        reading_q <= reading_d;
  end

  // binary output
  gds_sel_t binSel;
  assign binSel = gds_sel_t'(cfg_q.binSel);
  logic trig;

  always_comb begin
    unique case (binSel)
      SEL_WARN:   trig = inWarn;
      SEL_ALARM:  trig = inAlarm;
      SEL_EITHER: trig = inWarn || inAlarm;
      default:    trig = 1'b0;
    endcase
  end

  logic latched_q;
  wire  binActive = cfg_q.binLatch ? (latched_q || trig) : trig;
  wire  binLevel  = cfg_q.binIdleHigh ? ~binActive : binActive;

  // a trigger in the clearing cycle keeps the latch set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      latched_q <= 1'b0;
    else if (cfg_q.binLatch && trig)
      latched_q <= 1'b1;
    else if (clrLatchReq || !cfg_q.binLatch)
      latched_q <= 1'b0;
  end

  // converter code
  gds_mode_t mode;
  assign mode = gds_mode_t'(cfg_q.outMode);
  wire [8:0] propSum  = {1'b0, reading_d} + {3'b000, DAC_OFFSET};
  wire [5:0] propCode = (propSum > {3'b000, DAC_MAX}) ? DAC_MAX
                                                      : propSum[5:0];
  logic [5:0] stepCode;
  logic [5:0] dac_d;

  always_comb begin
    unique case (state_q)
      ST_WARMUP:  stepCode = STEP_NORMAL;
      ST_NORMAL:  stepCode = STEP_NORMAL;
      ST_WARNING: stepCode = STEP_WARN;
      ST_ALARM:   stepCode = STEP_ALARM;
      ST_ERROR:   stepCode = STEP_ERROR;
      default:    stepCode = STEP_ERROR;
    endcase
  end

  always_comb begin
    unique case (mode)
      MODE_STEP: dac_d = stepCode;
      MODE_PROP: dac_d = inError ? 6'h00 : propCode;
      default:   dac_d = 6'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dacCode <= 6'h00;
      binOut  <= 1'b0;
    end else begin
      dacCode <= dac_d;
      binOut  <= (mode == MODE_BINARY) ? binLevel : 1'b0;
    end
  end

  // status indicator
  gds_led_drive #(
    .BlinkCycles     (BlinkCycles),
    .ErrPeriodCycles (ErrPeriodCycles),
    .ErrPulseCycles  (ErrPulseCycles)
  ) u_led (
    .clk      (clk),
    .rst_n    (rst_n),
    .state    (state_q),
    .ledRed   (ledRed),
    .ledGreen (ledGreen)
  );

  // register read, answered the cycle after the strobe
  wire [2:0] stateCode = 3'(state_q);
  wire [7:0] statusWord = {faults, latched_q, binActive, stateCode};
  logic [7:0] rdMux;

  always_comb begin
    unique case (regAddr)
      REG_CTRL:    rdMux = cfg_q;
      REG_ALARM:   rdMux = alarmThr_q;
      REG_WARNPCT: rdMux = warnPct_q;
      REG_BASE:    rdMux = baseline_q;
      REG_SPAN:    rdMux = span_q;
      REG_TCOEF:   rdMux = tcoef_q;
      REG_STATUS:  rdMux = statusWord;
      REG_READING: rdMux = reading_q;
    endcase
  end

  // data held at zero outside the answer cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) regRdData <= 8'h00;
    else        regRdData <= regRd ? rdMux : 8'h00;
  end
endmodule
`default_nettype wire
